// file: pkg/bst_regs.svh
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
// instruction width and codes (all-ones is bypass)
`define BST_IR_W 3
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLEZ 3'h2
`define BST_OP_SAMPLE 3'h4
`define BST_OP_BYPASS 3'h7
// capture-ir pattern in the two low bits
`define BST_IR_CAPTURE 3'h1
// boundary register cells holding the output enables
`define BST_CELL_OE_B 49
`define BST_CELL_OE_A 50
// tms-high edges that force test-logic reset
`define BST_TMS_RESET_EDGES 5
`endif

// file: pkg/bst_pkg.sv
package bst_pkg;
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR,
    PAUSE_IR, EXIT2_IR, UPDATE_IR
  } bst_state_e;
endpackage : bst_pkg

// file: hdl/bst_tap.sv
`timescale 1ns/100ps
`include "bst_regs.svh"
module bst_tap #(
  parameter int BSR_W = 64,
  parameter logic [31:0] ID_CODE = 32'h1234_5671 // value arbitrary
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic [BSR_W-1:0] pin_ring,
  output logic tdo,
  output logic tdo_oe,
  output logic [BSR_W-1:0] bsr_out,
  output logic extest_mode,
  output logic port_a_oe,
  output logic port_b_oe,
  output logic outputs_float,
  output logic on_die_termination_off
);
  typedef struct packed {
    logic [2:0] tck_s;
    logic [2:0] tms_s;
    logic [2:0] tdi_s;
    logic [2:0] trst_s;
    logic tck_q;
    logic tms_q;
    logic tdi_q;
    logic trst_q;
    bst_pkg::bst_state_e st;
    logic [2:0] tms_hi;
    logic [2:0] ir_sh;
    logic [2:0] ir;
    logic byp;
    logic [31:0] id_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] bsr_up;
    logic tdo;
    logic tdo_oe;
  } bst_state_s;

  bst_state_s cur_ff, nxt_cur;
  logic rise, fall, sh_bit, sel_bsr;

  //////////////////////////////////////////////////////////////////////////
  // next state: pin sync, tap machine, scan registers
  always_comb begin
    nxt_cur = cur_ff;
    // three-stage sync; level accepted when stages two and three agree
    nxt_cur.tck_s = {cur_ff.tck_s[1:0], tck};
    nxt_cur.tms_s = {cur_ff.tms_s[1:0], tms};
    nxt_cur.tdi_s = {cur_ff.tdi_s[1:0], tdi};
    nxt_cur.trst_s = {cur_ff.trst_s[1:0], trst_n};
    if (cur_ff.tck_s[2] == cur_ff.tck_s[1]) nxt_cur.tck_q = cur_ff.tck_s[2];
    if (cur_ff.tms_s[2] == cur_ff.tms_s[1]) nxt_cur.tms_q = cur_ff.tms_s[2];
    if (cur_ff.tdi_s[2] == cur_ff.tdi_s[1]) nxt_cur.tdi_q = cur_ff.tdi_s[2];
    if (cur_ff.trst_s[2] == cur_ff.trst_s[1]) nxt_cur.trst_q = cur_ff.trst_s[2];
    rise = !cur_ff.tck_q && nxt_cur.tck_q;
    fall = cur_ff.tck_q && !nxt_cur.tck_q;
    sel_bsr = (cur_ff.ir == `BST_OP_EXTEST) || (cur_ff.ir == `BST_OP_SAMPLE) ||
              (cur_ff.ir == `BST_OP_SAMPLEZ);
    // only the selected register feeds tdo
    // a priority chain: shift-ir and a boundary instruction can both be true
    if (cur_ff.st == bst_pkg::SHIFT_IR) sh_bit = cur_ff.ir_sh[0];
    else if (sel_bsr) sh_bit = cur_ff.bsr_sh[0];
    else if (cur_ff.ir == `BST_OP_IDCODE) sh_bit = cur_ff.id_sh[0];
    else sh_bit = cur_ff.byp; // reserved codes fall back to bypass
    // sampled tms/tdi used only on a rising tck edge
    if (rise) begin
      nxt_cur.tms_hi = cur_ff.tms_q ? ((cur_ff.tms_hi == 3'h7) ? 3'h7 : cur_ff.tms_hi + 3'h1)
                                    : 3'h0;
      unique case (cur_ff.st)
        bst_pkg::TEST_LOGIC_RESET: nxt_cur.st = cur_ff.tms_q ? bst_pkg::TEST_LOGIC_RESET
                                                             : bst_pkg::RUN_TEST_IDLE;
        bst_pkg::RUN_TEST_IDLE: nxt_cur.st = cur_ff.tms_q ? bst_pkg::SELECT_DR
                                                          : bst_pkg::RUN_TEST_IDLE;
        bst_pkg::SELECT_DR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::SELECT_IR : bst_pkg::CAPTURE_DR;
        bst_pkg::CAPTURE_DR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
        bst_pkg::SHIFT_DR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
        bst_pkg::EXIT1_DR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::UPDATE_DR : bst_pkg::PAUSE_DR;
        bst_pkg::PAUSE_DR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::EXIT2_DR : bst_pkg::PAUSE_DR;
        bst_pkg::EXIT2_DR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::UPDATE_DR : bst_pkg::SHIFT_DR;
        bst_pkg::UPDATE_DR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::SELECT_DR
                                                      : bst_pkg::RUN_TEST_IDLE;
        bst_pkg::SELECT_IR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::TEST_LOGIC_RESET
                                                      : bst_pkg::CAPTURE_IR;
        bst_pkg::CAPTURE_IR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
        bst_pkg::SHIFT_IR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
        bst_pkg::EXIT1_IR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::UPDATE_IR : bst_pkg::PAUSE_IR;
        bst_pkg::PAUSE_IR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::EXIT2_IR : bst_pkg::PAUSE_IR;
        bst_pkg::EXIT2_IR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::UPDATE_IR : bst_pkg::SHIFT_IR;
        bst_pkg::UPDATE_IR: nxt_cur.st = cur_ff.tms_q ? bst_pkg::SELECT_DR
                                                      : bst_pkg::RUN_TEST_IDLE;
      endcase
      // the state graph already guarantees this; the counter is a belt-and-braces path
      if (cur_ff.tms_q && (cur_ff.tms_hi >= 3'(`BST_TMS_RESET_EDGES - 1)))
        nxt_cur.st = bst_pkg::TEST_LOGIC_RESET;
      // register actions of the state being left
      unique case (cur_ff.st)
        bst_pkg::CAPTURE_IR: nxt_cur.ir_sh = `BST_IR_CAPTURE;
        bst_pkg::SHIFT_IR: nxt_cur.ir_sh = {cur_ff.tdi_q, cur_ff.ir_sh[2:1]};
        bst_pkg::UPDATE_IR: nxt_cur.ir = cur_ff.ir_sh;
        bst_pkg::CAPTURE_DR: begin
          if (sel_bsr) nxt_cur.bsr_sh = pin_ring;
          else if (cur_ff.ir == `BST_OP_IDCODE) nxt_cur.id_sh = ID_CODE;
          else nxt_cur.byp = 1'b0;
        end
        bst_pkg::SHIFT_DR: begin
          if (sel_bsr) nxt_cur.bsr_sh = {cur_ff.tdi_q, cur_ff.bsr_sh[BSR_W-1:1]};
          else if (cur_ff.ir == `BST_OP_IDCODE) nxt_cur.id_sh = {cur_ff.tdi_q, cur_ff.id_sh[31:1]};
          else nxt_cur.byp = cur_ff.tdi_q;
        end
        bst_pkg::UPDATE_DR: if (sel_bsr) nxt_cur.bsr_up = cur_ff.bsr_sh;
        default: ;
      endcase
    end
    // tdo and its enable move on a falling tck edge; test-logic reset below also clears them at any time
    if (fall) begin
      nxt_cur.tdo_oe = (cur_ff.st == bst_pkg::SHIFT_DR) || (cur_ff.st == bst_pkg::SHIFT_IR);
      nxt_cur.tdo = nxt_cur.tdo_oe ? sh_bit : 1'b0;
    end
    // test-logic reset: idcode, enable cells cleared, tdo off
    if (!cur_ff.trst_q || nxt_cur.st == bst_pkg::TEST_LOGIC_RESET) begin
      nxt_cur.st = bst_pkg::TEST_LOGIC_RESET;
      nxt_cur.ir = `BST_OP_IDCODE;
      nxt_cur.bsr_up[`BST_CELL_OE_B] = 1'b0;
      nxt_cur.bsr_up[`BST_CELL_OE_A] = 1'b0;
      nxt_cur.tdo_oe = 1'b0;
      nxt_cur.tdo = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; power-up reset leaves tdo released and idcode loaded
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
      cur_ff.tms_s <= 3'h7;
      cur_ff.tdi_s <= 3'h7;
      cur_ff.trst_s <= 3'h7;
      cur_ff.tms_q <= 1'b1;
      cur_ff.tdi_q <= 1'b1;
      cur_ff.trst_q <= 1'b1;
      cur_ff.st <= bst_pkg::TEST_LOGIC_RESET;
      cur_ff.ir <= `BST_OP_IDCODE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; none of these touch memory traffic unless a test instruction is active
  assign tdo = cur_ff.tdo;
  assign tdo_oe = cur_ff.tdo_oe;
  assign bsr_out = cur_ff.bsr_up;
  assign extest_mode = (cur_ff.ir == `BST_OP_EXTEST);
  assign port_b_oe = extest_mode && cur_ff.bsr_up[`BST_CELL_OE_B];
  assign port_a_oe = extest_mode && cur_ff.bsr_up[`BST_CELL_OE_A];
  assign outputs_float = (cur_ff.ir == `BST_OP_SAMPLEZ);
  assign on_die_termination_off = sel_bsr;
endmodule : bst_tap

// file: sim/bst_tap_asserts.sv
`timescale 1ns/100ps
`include "bst_regs.svh"
module bst_tap_asserts #(
  parameter int BSR_W = 64
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [BSR_W-1:0] bsr_out,
  input wire logic extest_mode,
  input wire logic port_a_oe,
  input wire logic port_b_oe,
  input wire logic outputs_float,
  input wire logic on_die_termination_off
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // tck is sampled late, so an edge-bound output must lag the pin edge
  tdo_edge_a: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
    else $error("tdo moved outside tck low phase");
  oe_edge_a: assert property ($changed(tdo_oe) |-> !tck && !$past(tck, 2))
    else $error("tdo_oe moved outside tck low phase");
  trst_clear_a: assert property (!trst_n [*6] |->
      !tdo_oe && !extest_mode && !port_a_oe && !port_b_oe)
    else $error("test reset did not clear controller");
  odt_mode_a: assert property (extest_mode || outputs_float |-> on_die_termination_off)
    else $error("termination left on in scan mode");
  oe_a_map_a: assert property (port_a_oe == (extest_mode && bsr_out[`BST_CELL_OE_A]))
    else $error("port a enable mismatch");
  oe_b_map_a: assert property (port_b_oe == (extest_mode && bsr_out[`BST_CELL_OE_B]))
    else $error("port b enable mismatch");
  // trst forces cells 49/50 while tck idles, so those moments are excluded
  update_edge_a: assert property ($changed(bsr_out) && trst_n && $past(trst_n, 6) |-> tck)
    else $error("update latch moved outside tck high");
  mode_edge_a: assert property (($changed(extest_mode) || $changed(outputs_float)) && trst_n
      && $past(trst_n, 6) |-> tck)
    else $error("instruction changed outside update");
  cover property (extest_mode && port_a_oe && port_b_oe);
  cover property (outputs_float && tdo_oe);
  cover property (!trst_n [*6]);
endmodule : bst_tap_asserts

// file: sim/bst_host_model.sv
`timescale 1ns/100ps
module bst_host_model (
  input wire logic mclk,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n
);
  // idle: tck parked low, pulled-up pins read high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
  end
  // one 125 ns tck cycle; tms/tdi set up a half period before the rise
  task automatic step(input logic m, input logic d);
    @(negedge mclk);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    #62.5 tck = 1'b0;
  endtask : step
  task automatic test_reset();
    @(negedge mclk);
    trst_n = 1'b0;
    repeat (12) @(negedge mclk);
    trst_n = 1'b1;
  endtask : test_reset
endmodule : bst_host_model

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] ID = 32'h0BADF00D; // value arbitrary
  logic mclk, resetn, tck, tms, tdi, trst_n, tdo, tdo_oe, ext, pa, pb, flt, on_die_termination, sel;
  logic [63:0] pin_ring, bsr_out, d;
  logic exp_q[$];
  int error_cnt = 0, n_checks = 0, seed = 32'h0af3;
  bst_tap #(.BSR_W(64), .ID_CODE(ID)) u_dut (.mclk(mclk), .resetn(resetn), .tck(tck),
    .tms(tms), .tdi(tdi), .trst_n(trst_n), .pin_ring(pin_ring), .tdo(tdo), .tdo_oe(tdo_oe),
    .bsr_out(bsr_out), .extest_mode(ext), .port_a_oe(pa), .port_b_oe(pb),
    .outputs_float(flt), .on_die_termination_off(on_die_termination));
  bst_host_model u_host (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    chk("queue_left", 64'h0, 64'(exp_q.size()));
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // shift len bits then pass update back to run-test-idle
  task automatic shift(input int len, input logic [63:0] v);
    for (int i = 0; i < len; i++) u_host.step(i == len - 1, v[i]);
    u_host.step(1'b1, 1'b1);
    u_host.step(1'b0, 1'b1);
  endtask : shift
  task automatic load_ir(input logic [2:0] c);
    exp_q.push_back(1'b1);
    exp_q.push_back(1'b0);
    exp_q.push_back(1'b0);
    for (int i = 0; i < 4; i++) u_host.step(i < 2, 1'b1);
    shift(3, {61'h0, c});
  endtask : load_ir
  // register of r bits: its capture leaves first, then tdi bits follow
  task automatic scan_dr(input int len, input int r, input logic [63:0] cap);
    for (int i = 0; i < len; i++) exp_q.push_back(i < r ? cap[i] : d[i - r]);
    for (int i = 0; i < 3; i++) u_host.step(i == 0, 1'b1);
    shift(len, d);
  endtask : scan_dr
  // scoreboard: every driven tdo bit is matched against the oldest note
  always @(posedge tck) begin
    if (tdo_oe === 1'b1) chk("tdo", exp_q.size() ? 64'(exp_q.pop_front()) : 64'hX, 64'(tdo));
  end
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    pin_ring = 64'h0;
    d = 64'h0;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    repeat (8) @(negedge mclk);
    u_host.step(1'b0, 1'b1);
    scan_dr(32, 32, {32'h0, ID});
    chk("tdo_oe_idle", 64'h0, 64'(tdo_oe));
    for (int c = 0; c < 8; c++) begin
      load_ir(c[2:0]);
      @(negedge mclk);
      pin_ring = {$random(seed), $random(seed)};
      d = {$random(seed), $random(seed)};
      sel = (c == 0 || c == 2 || c == 4);
      if (sel) scan_dr(64, 64, pin_ring);
      else if (c == 1) scan_dr(32, 32, {32'h0, ID});
      else scan_dr(3, 1, 64'h0);
      if (sel) chk("bsr_out", d, bsr_out);
      chk("extest_mode", 64'(c == 0), 64'(ext));
      chk("port_a_oe", 64'(c == 0 && d[50]), 64'(pa));
      chk("port_b_oe", 64'(c == 0 && d[49]), 64'(pb));
      chk("outputs_float", 64'(c == 2), 64'(flt));
      chk("odt_off", 64'(sel), 64'(on_die_termination));
    end
    for (int i = 0; i < 5; i++) u_host.step(1'b1, 1'b1);
    u_host.step(1'b0, 1'b1);
    scan_dr(32, 32, {32'h0, ID});
    // set both enable cells under extest so the reset really has work to do
    load_ir(3'h0);
    d = 64'h0006_0000_0000_0000;
    scan_dr(64, 64, pin_ring);
    chk("port_oe_set", 64'h3, {62'h0, pa, pb});
    u_host.test_reset();
    repeat (8) @(negedge mclk);
    chk("oe_cells", 64'h0, {62'h0, bsr_out[50], bsr_out[49]});
    chk("port_oe", 64'h0, {62'h0, pa, pb});
    chk("extest_mode_rst", 64'h0, 64'(ext));
    u_host.step(1'b0, 1'b1);
    scan_dr(32, 32, {32'h0, ID});
    chk("tdo_oe_end", 64'h0, 64'(tdo_oe));
    print_verdict();
  end
endmodule : testbench
bind bst_tap bst_tap_asserts #(.BSR_W(BSR_W)) u_chk (.mclk(mclk), .resetn(resetn), .tck(tck),
  .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .bsr_out(bsr_out), .extest_mode(extest_mode),
  .port_a_oe(port_a_oe), .port_b_oe(port_b_oe), .outputs_float(outputs_float),
  .on_die_termination_off(on_die_termination_off));
